// >>> src/dfv_map.svh
// Register offsets, field positions, reset values and timing counts of the drive block.
`ifndef DFV_MAP_SVH
`define DFV_MAP_SVH
`define DFV_A_MAIN_FREQ 8'h00
`define DFV_A_REV_SEL 8'h04
`define DFV_A_MAX_FREQ 8'h08
`define DFV_A_MIN_FREQ 8'h0C
`define DFV_A_ACC 8'h10
`define DFV_A_DEC 8'h14
`define DFV_A_ALT_ACC 8'h18
`define DFV_A_ALT_DEC 8'h1C
`define DFV_A_V_MAX 8'h20
`define DFV_A_F_BASE 8'h24
`define DFV_A_V_MID 8'h28
`define DFV_A_F_MID 8'h2C
`define DFV_A_V_MIN 8'h30
`define DFV_A_F_MIN 8'h34
`define DFV_A_CARRIER 8'h38
`define DFV_A_RESTORE 8'h3C
`define DFV_A_LOCK 8'h40
`define DFV_A_START_MODE 8'h44
`define DFV_A_START_FREQ 8'h48
`define DFV_A_CTRL 8'h4C
`define DFV_A_STATUS 8'h50
`define DFV_A_VOLTAGE 8'h54
`define DFV_CTRL_RUN 0
`define DFV_CTRL_REV 1
`define DFV_FREQ_CEIL 16'h9C40
`define DFV_VOLT_CEIL 16'hC350
`define DFV_TIME_MIN 14'h0001
`define DFV_TIME_MAX 14'h270F
`define DFV_START_MIN 16'h000A
`define DFV_START_MAX 16'h03E8
`define DFV_RESTORE_CODE 4'h8
`define DFV_RESTORE_MAX 4'h8
`define DFV_CARRIER_MIN 4'h1
`define DFV_CARRIER_MAX 4'hF
`define DFV_RST_MAX_FREQ 16'h1388
`define DFV_RST_MIN_FREQ 16'h0000
`define DFV_RST_V_MAX 16'h9470
`define DFV_RST_F_MID 16'h00FA
`define DFV_RST_V_MIN 16'h05DC
`define DFV_RST_F_MIN 16'h007D
`define DFV_RST_START_FREQ 16'h0032
`define DFV_CLK_NS 50
`define DFV_TICK_NS 2500
`define DFV_RAMP_UNIT_NS 100000000
`endif

// >>> src/dfv_pkg.sv
// Types shared by the drive block: parameter set, drive outputs and sequencer states.
package dfv_pkg;
	// Every software setting; frequencies in 0.01 Hz, voltages in 0.01 V, times in 0.1 s.
	typedef struct packed {
		logic [15:0] main_digital_freq;
		logic reverse_prevention_sel;
		logic [15:0] max_output_freq;
		logic [15:0] min_output_freq;
		logic [13:0] accel_time;
		logic [13:0] decel_time;
		logic [13:0] alt_accel_time;
		logic [13:0] alt_decel_time;
		logic [15:0] curve_max_voltage;
		logic [15:0] curve_base_freq;
		logic [15:0] curve_mid_voltage;
		logic [15:0] curve_mid_freq;
		logic [15:0] curve_min_voltage;
		logic [15:0] curve_min_freq;
		logic [3:0] pwm_carrier_sel;
		logic [3:0] factory_restore_cmd;
		logic param_lock;
		logic start_mode_sel;
		logic [15:0] start_freq;
	} dfv_param_type;
	// Command to the power stage.
	typedef struct packed {
		logic running;
		logic reverse;
		logic [15:0] freq;
		logic [15:0] voltage;
		logic [3:0] carrier;
	} dfv_drive_type;
	// Output sequencer states.
	typedef enum logic [1:0] {DFV_IDLE, DFV_TRACE, DFV_RAMP} dfv_state_type;
endpackage : dfv_pkg

// >>> src/dfv_core.sv
// Drive frequency ramp and volts-per-hertz block with its AHB-Lite register slave.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "dfv_map.svh"
module dfv_core #(
	parameter logic [13:0] RST_ACCEL = 14'h0046,
	parameter logic [13:0] RST_DECEL = 14'h0046,
	parameter logic [15:0] RST_MID_VOLT = 16'h05DC,
	parameter logic [3:0] RST_CARRIER = 4'hA,
	parameter logic [15:0] RST_BASE_FREQ = 16'h1388
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic alt_ramp_sel,
	input wire logic speed_found,
	output dfv_pkg::dfv_drive_type drive
);
	import dfv_pkg::*;

	// Ramp tick period and number of ticks in one 0.1 s unit of ramp time.
	localparam int TICK_CYC = `DFV_TICK_NS / `DFV_CLK_NS;
	localparam logic [31:0] TICKS_PER_UNIT = 32'(`DFV_RAMP_UNIT_NS / `DFV_TICK_NS);
	// Factory parameter set, model-dependent fields from the module parameters.
	localparam dfv_param_type RST_CFG = '{
		main_digital_freq: 16'h0000, reverse_prevention_sel: 1'b1,
		max_output_freq: `DFV_RST_MAX_FREQ, min_output_freq: `DFV_RST_MIN_FREQ,
		accel_time: RST_ACCEL, decel_time: RST_DECEL,
		alt_accel_time: RST_ACCEL, alt_decel_time: RST_DECEL,
		curve_max_voltage: `DFV_RST_V_MAX, curve_base_freq: RST_BASE_FREQ,
		curve_mid_voltage: RST_MID_VOLT, curve_mid_freq: `DFV_RST_F_MID,
		curve_min_voltage: `DFV_RST_V_MIN, curve_min_freq: `DFV_RST_F_MIN,
		pwm_carrier_sel: RST_CARRIER, factory_restore_cmd: 4'h0,
		param_lock: 1'b0, start_mode_sel: 1'b0, start_freq: `DFV_RST_START_FREQ};

	dfv_param_type cfg; // Live settings.
	dfv_param_type next_cfg; // Settings as the pending write would leave them.
	logic wr_pend; // A write data phase is in progress.
	logic rd_pend; // A read data phase is in progress.
	logic [7:0] acc_addr; // Address captured in the address phase.
	logic cand_ok; // Candidate settings are consistent.
	logic lock_ok; // The lock lets this address be written.
	logic write_refused; // Last parameter write was refused.
	logic run_cmd; // Software run request.
	logic rev_cmd; // Software reverse request.
	logic [1:0] alt_sync; // Synchroniser for the ramp-select terminal.
	logic [1:0] found_sync; // Synchroniser for the speed-found input.
	dfv_state_type state; // Output sequencer state.
	logic [15:0] out_freq; // Present output frequency.
	logic out_rev; // Present direction, high for reverse.
	logic [7:0] tick_cnt; // Divider to the ramp tick.
	logic tick; // One-cycle ramp tick.
	logic [31:0] ramp_acc; // Fractional ramp accumulator.
	logic [15:0] clamped; // Command clamped between the limits.
	logic dir_want; // Direction software may have.
	logic [15:0] target; // Frequency the ramp heads for.
	logic [13:0] ramp_time; // Active ramp time.
	logic [31:0] ramp_limit; // Accumulator threshold for one step.
	logic step; // One 0.01 Hz step is due this tick.
	logic [15:0] volt; // Interpolated voltage.

	// Zero-wait slave; every answer is OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Capture the address phase of each accepted transfer.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			acc_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			rd_pend <= hsel && htrans[1] && !hwrite;
			acc_addr <= haddr[7:0];
		end
	end

	// Build the settings the write would produce; unmapped addresses change nothing.
	always_comb begin
		next_cfg = cfg;
		case (acc_addr)
			`DFV_A_MAIN_FREQ: next_cfg.main_digital_freq = hwdata[15:0];
			`DFV_A_REV_SEL: next_cfg.reverse_prevention_sel = hwdata[0];
			`DFV_A_MAX_FREQ: next_cfg.max_output_freq = hwdata[15:0];
			`DFV_A_MIN_FREQ: next_cfg.min_output_freq = hwdata[15:0];
			`DFV_A_ACC: next_cfg.accel_time = hwdata[13:0];
			`DFV_A_DEC: next_cfg.decel_time = hwdata[13:0];
			`DFV_A_ALT_ACC: next_cfg.alt_accel_time = hwdata[13:0];
			`DFV_A_ALT_DEC: next_cfg.alt_decel_time = hwdata[13:0];
			`DFV_A_V_MAX: next_cfg.curve_max_voltage = hwdata[15:0];
			`DFV_A_F_BASE: next_cfg.curve_base_freq = hwdata[15:0];
			`DFV_A_V_MID: next_cfg.curve_mid_voltage = hwdata[15:0];
			`DFV_A_F_MID: next_cfg.curve_mid_freq = hwdata[15:0];
			`DFV_A_V_MIN: next_cfg.curve_min_voltage = hwdata[15:0];
			`DFV_A_F_MIN: next_cfg.curve_min_freq = hwdata[15:0];
			`DFV_A_CARRIER: next_cfg.pwm_carrier_sel = hwdata[3:0];
			`DFV_A_RESTORE: next_cfg.factory_restore_cmd = hwdata[3:0];
			`DFV_A_LOCK: next_cfg.param_lock = hwdata[0];
			`DFV_A_START_MODE: next_cfg.start_mode_sel = hwdata[0];
			`DFV_A_START_FREQ: next_cfg.start_freq = hwdata[15:0];
			default: next_cfg = cfg;
		endcase
		// Ranges and orderings that every stored set must keep; bits above a field are ignored.
		cand_ok = (next_cfg.max_output_freq <= `DFV_FREQ_CEIL)
			&& (next_cfg.min_output_freq <= next_cfg.max_output_freq)
			&& (next_cfg.accel_time >= `DFV_TIME_MIN) && (next_cfg.accel_time <= `DFV_TIME_MAX)
			&& (next_cfg.decel_time >= `DFV_TIME_MIN) && (next_cfg.decel_time <= `DFV_TIME_MAX)
			&& (next_cfg.alt_accel_time >= `DFV_TIME_MIN)
			&& (next_cfg.alt_accel_time <= `DFV_TIME_MAX)
			&& (next_cfg.alt_decel_time >= `DFV_TIME_MIN)
			&& (next_cfg.alt_decel_time <= `DFV_TIME_MAX)
			&& (next_cfg.curve_min_freq <= next_cfg.curve_mid_freq)
			&& (next_cfg.curve_mid_freq <= next_cfg.curve_base_freq)
			&& (next_cfg.curve_base_freq <= next_cfg.max_output_freq)
			&& (next_cfg.curve_min_voltage <= next_cfg.curve_mid_voltage)
			&& (next_cfg.curve_mid_voltage <= next_cfg.curve_max_voltage)
			&& (next_cfg.curve_max_voltage <= `DFV_VOLT_CEIL)
			&& (next_cfg.pwm_carrier_sel >= `DFV_CARRIER_MIN)
			&& (next_cfg.pwm_carrier_sel <= `DFV_CARRIER_MAX)
			&& (next_cfg.factory_restore_cmd <= `DFV_RESTORE_MAX)
			&& (next_cfg.start_freq >= `DFV_START_MIN)
			&& (next_cfg.start_freq <= `DFV_START_MAX);
		// Locked: only the main frequency and the lock itself may change.
		lock_ok = !cfg.param_lock || (acc_addr == `DFV_A_MAIN_FREQ)
			|| (acc_addr == `DFV_A_LOCK);
	end

	// Commit a write, or a restore, or refuse it and leave the settings untouched.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg <= RST_CFG;
			write_refused <= 1'b0;
		end else if (wr_pend && (acc_addr <= `DFV_A_START_FREQ)) begin
			if (!lock_ok || !cand_ok) begin
				write_refused <= 1'b1;
			end else if (next_cfg.factory_restore_cmd == `DFV_RESTORE_CODE) begin
				cfg <= RST_CFG;
				write_refused <= 1'b0;
			end else begin
				cfg <= next_cfg;
				write_refused <= 1'b0;
			end
		end
	end

	// Run and direction requests from the control register; not a locked parameter.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_cmd <= 1'b0;
			rev_cmd <= 1'b0;
		end else if (wr_pend && (acc_addr == `DFV_A_CTRL)) begin
			run_cmd <= hwdata[`DFV_CTRL_RUN];
			rev_cmd <= hwdata[`DFV_CTRL_REV];
		end
	end

	// Read data, muxed from registers during the data phase.
	always_comb begin
		hrdata = 32'h0000_0000;
		if (rd_pend) begin
			case (acc_addr)
				`DFV_A_MAIN_FREQ: hrdata[15:0] = cfg.main_digital_freq;
				`DFV_A_REV_SEL: hrdata[0] = cfg.reverse_prevention_sel;
				`DFV_A_MAX_FREQ: hrdata[15:0] = cfg.max_output_freq;
				`DFV_A_MIN_FREQ: hrdata[15:0] = cfg.min_output_freq;
				`DFV_A_ACC: hrdata[13:0] = cfg.accel_time;
				`DFV_A_DEC: hrdata[13:0] = cfg.decel_time;
				`DFV_A_ALT_ACC: hrdata[13:0] = cfg.alt_accel_time;
				`DFV_A_ALT_DEC: hrdata[13:0] = cfg.alt_decel_time;
				`DFV_A_V_MAX: hrdata[15:0] = cfg.curve_max_voltage;
				`DFV_A_F_BASE: hrdata[15:0] = cfg.curve_base_freq;
				`DFV_A_V_MID: hrdata[15:0] = cfg.curve_mid_voltage;
				`DFV_A_F_MID: hrdata[15:0] = cfg.curve_mid_freq;
				`DFV_A_V_MIN: hrdata[15:0] = cfg.curve_min_voltage;
				`DFV_A_F_MIN: hrdata[15:0] = cfg.curve_min_freq;
				`DFV_A_CARRIER: hrdata[3:0] = cfg.pwm_carrier_sel;
				`DFV_A_RESTORE: hrdata[3:0] = cfg.factory_restore_cmd;
				`DFV_A_LOCK: hrdata[0] = cfg.param_lock;
				`DFV_A_START_MODE: hrdata[0] = cfg.start_mode_sel;
				`DFV_A_START_FREQ: hrdata[15:0] = cfg.start_freq;
				`DFV_A_CTRL: hrdata[1:0] = {rev_cmd, run_cmd};
				`DFV_A_STATUS: hrdata[19:0] = {write_refused, state == DFV_TRACE,
					state != DFV_IDLE, out_rev, out_freq};
				`DFV_A_VOLTAGE: hrdata[15:0] = drive.voltage;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// Two-flop synchronisers for the terminal inputs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alt_sync <= 2'b00;
			found_sync <= 2'b00;
		end else begin
			alt_sync <= {alt_sync[0], alt_ramp_sel};
			found_sync <= {found_sync[0], speed_found};
		end
	end

	// Ramp tick divider.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt <= 8'h00;
			tick <= 1'b0;
		end else begin
			tick <= (tick_cnt == 8'(TICK_CYC - 1));
			tick_cnt <= (tick_cnt == 8'(TICK_CYC - 1)) ? 8'h00 : tick_cnt + 8'h01;
		end
	end

	// Target frequency, direction policy and the active ramp rate.
	always_comb begin
		clamped = cfg.main_digital_freq;
		if (clamped < cfg.min_output_freq) begin
			clamped = cfg.min_output_freq;
		end
		if (clamped > cfg.max_output_freq) begin
			clamped = cfg.max_output_freq;
		end
		dir_want = cfg.reverse_prevention_sel ? rev_cmd : 1'b0;
		target = (run_cmd && (dir_want == out_rev)) ? clamped : 16'h0000;
		if (out_freq < target) begin
			ramp_time = alt_sync[1] ? cfg.alt_accel_time : cfg.accel_time;
		end else begin
			ramp_time = alt_sync[1] ? cfg.alt_decel_time : cfg.decel_time;
		end
		// Max frequency added per tick against time in ticks: exact full-scale timing.
		ramp_limit = 32'(ramp_time) * TICKS_PER_UNIT;
		step = (ramp_acc + 32'(cfg.max_output_freq)) >= ramp_limit;
	end

	// Output sequencer: start, tracing sweep, ramp and direction change at standstill.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= DFV_IDLE;
			out_freq <= 16'h0000;
			out_rev <= 1'b0;
			ramp_acc <= 32'h0000_0000;
		end else begin
			case (state)
				DFV_IDLE: begin
					ramp_acc <= 32'h0000_0000;
					out_freq <= 16'h0000;
					if (dir_want != out_rev) begin
						out_rev <= dir_want;
					end else if (run_cmd && cfg.start_mode_sel) begin
						out_freq <= cfg.max_output_freq;
						state <= DFV_TRACE;
					end else if (run_cmd) begin
						out_freq <= cfg.start_freq;
						state <= DFV_RAMP;
					end
				end
				DFV_TRACE: begin
					// Sweep down at the decel rate until the motor speed is met.
					if (found_sync[1] || (out_freq <= target)) begin
						state <= DFV_RAMP;
						ramp_acc <= 32'h0000_0000;
					end else if (tick) begin
						ramp_acc <= step ? ramp_acc + 32'(cfg.max_output_freq) - ramp_limit
							: ramp_acc + 32'(cfg.max_output_freq);
						out_freq <= step ? out_freq - 16'h0001 : out_freq;
					end
				end
				DFV_RAMP: begin
					if (out_freq == target) begin
						ramp_acc <= 32'h0000_0000;
						if (target == 16'h0000) begin
							state <= DFV_IDLE;
						end
					end else if (tick) begin
						ramp_acc <= step ? ramp_acc + 32'(cfg.max_output_freq) - ramp_limit
							: ramp_acc + 32'(cfg.max_output_freq);
						if (step && (out_freq < target)) begin
							out_freq <= out_freq + 16'h0001;
						end else if (step) begin
							out_freq <= out_freq - 16'h0001;
						end
					end
				end
				default: state <= DFV_IDLE;
			endcase
		end
	end

	// Piecewise-linear voltage; each divisor is non-zero in its own branch.
	always_comb begin
		if (out_freq <= cfg.curve_min_freq) begin
			volt = cfg.curve_min_voltage;
		end else if (out_freq >= cfg.curve_base_freq) begin
			volt = cfg.curve_max_voltage;
		end else if (out_freq < cfg.curve_mid_freq) begin
			volt = cfg.curve_min_voltage + 16'((32'(out_freq - cfg.curve_min_freq)
				* 32'(cfg.curve_mid_voltage - cfg.curve_min_voltage))
				/ 32'(cfg.curve_mid_freq - cfg.curve_min_freq));
		end else begin
			volt = cfg.curve_mid_voltage + 16'((32'(out_freq - cfg.curve_mid_freq)
				* 32'(cfg.curve_max_voltage - cfg.curve_mid_voltage))
				/ 32'(cfg.curve_base_freq - cfg.curve_mid_freq));
		end
	end

	// Registered command to the power stage.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive <= '0;
		end else begin
			drive.running <= (state != DFV_IDLE);
			drive.reverse <= out_rev;
			drive.freq <= out_freq;
			drive.voltage <= (state != DFV_IDLE) ? volt : 16'h0000;
			drive.carrier <= cfg.pwm_carrier_sel;
		end
	end
endmodule : dfv_core

// >>> dv/dfv_core_asserts.sv
// Checker on the drive block ports: bus answers, ramp stepping, curve and carrier limits.
`timescale 1ns/1ns
module dfv_core_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input dfv_pkg::dfv_drive_type drive
);
	import dfv_pkg::*;
	logic rd_ph; // High during a read data phase.
	logic [7:0] gap; // Cycles since the output frequency last moved.
	logic step_ok; // The last move was a ramp step, not a jump at start.
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Tracks read data phases and the spacing of frequency steps.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ph <= 1'b0;
			gap <= 8'h00;
			step_ok <= 1'b0;
		end else begin
			rd_ph <= hready && hsel && htrans[1] && !hwrite;
			gap <= $changed(drive.freq) ? 8'h00 : gap + {7'h00, gap != 8'hFF};
			if ($changed(drive.freq)) begin
				step_ok <= drive.running && $past(drive.running);
			end
		end
	end
	AST_FREQ_CEIL: assert property (drive.freq <= 16'h9C40)
		else $error("output frequency above ceiling");
	AST_VOLT_CEIL: assert property (drive.voltage <= 16'hC350)
		else $error("output voltage above ceiling");
	AST_IDLE_ZERO: assert property (!drive.running |-> drive.freq == 16'h0000 && drive.voltage == 16'h0000)
		else $error("idle output not zero");
	AST_CARRIER_RANGE: assert property ($past(hresetn) |-> drive.carrier inside {[4'h1:4'hF]})
		else $error("carrier outside its range");
	AST_STEP_ONE: assert property (drive.running && $past(drive.running) |->
		drive.freq + 16'h0001 >= $past(drive.freq) && drive.freq <= $past(drive.freq) + 16'h0001)
		else $error("frequency moved by more than one step");
	AST_STEP_SPACING: assert property ($changed(drive.freq) && drive.running && $past(drive.running) && step_ok |-> gap >= 8'h28)
		else $error("frequency steps closer than one tick");
	AST_DIR_STABLE: assert property (drive.running && $past(drive.running) |-> $stable(drive.reverse))
		else $error("direction flipped while running");
	AST_VOLT_MONO: assert property (drive.running && $past(drive.running) && drive.freq > $past(drive.freq) |-> drive.voltage >= $past(drive.voltage))
		else $error("voltage fell while frequency rose");
	AST_HRDATA_IDLE: assert property (!rd_ph |-> hrdata == 32'h00000000) // Bus data only in phase.
		else $error("read data outside a read data phase");
	AST_BUS_OKAY: assert property (hreadyout && !hresp) // Zero wait, always OKAY.
		else $error("bus answer not ready or not okay");
	cover property (drive.running && drive.reverse);
	cover property (drive.running && drive.freq == 16'h9C40);
	cover property (rd_ph && hrdata != 32'h00000000);
endmodule : dfv_core_asserts
bind dfv_core dfv_core_asserts u_asserts (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hresp(hresp),
	.hrdata(hrdata),
	.drive(drive)
);

// >>> dv/dfv_motor.sv
// Behavioural power stage and motor that reports when a tracing sweep meets the shaft speed.
`timescale 1ns/1ns
module dfv_motor (
	input wire logic hclk,
	input dfv_pkg::dfv_drive_type drive,
	input wire logic [15:0] spin_val,
	output logic speed_found
);
	import dfv_pkg::*;
	// The shaft coasts at the speed the bench sets; a match shows once the sweep reaches it.
	always_ff @(posedge hclk) begin
		speed_found <= drive.running && drive.freq <= spin_val;
	end
endmodule : dfv_motor

// >>> dv/dfv_core_tb.sv
// Self-checking bench for the drive block: registers, ramps, curve, direction and start modes.
`timescale 1ns/1ns
module dfv_core_tb;
	import dfv_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, found, rd_ph = 1'b0, alt_sel = 1'b0;
	logic [31:0] hrdata;
	logic [15:0] spin = 16'h0000; // Shaft speed offered by the motor model.
	logic [3:0] car; // Random carrier setting.
	logic [31:0] q[$]; // Expected read data, oldest first.
	int n_fail = 0, checks = 0, seed = 59181;
	dfv_drive_type drive;
	// Reset values: offset and value.
	logic [23:0] dfl [19] = '{24'h040001, 24'h081388, 24'h0C0000, 24'h100046, 24'h140046,
		24'h180046, 24'h1C0046, 24'h209470, 24'h241388, 24'h2805DC, 24'h2C00FA, 24'h3005DC,
		24'h34007D, 24'h38000A, 24'h3C0000, 24'h400000, 24'h440000, 24'h480032, 24'h600000};
	// Refused writes: offset, written value, value kept.
	logic [39:0] bad [14] = '{40'h089C411388, 40'h0C13890000, 40'h2C138900FA, 40'h2413891388,
		40'h28947105DC, 40'h20C3519470, 40'h1000000046, 40'h1427100046, 40'h381000000A,
		40'h380000000A, 40'h3C00090000, 40'h4800090032, 40'h4803E90032, 40'h0C13890000};
	// Ramp setup; the last entry starts a reverse run while reverse is prohibited.
	logic [23:0] cfg [9] = '{24'h089C40, 24'h100001, 24'h140001, 24'h180002, 24'h3003E8,
		24'h0C0064, 24'h000050, 24'h040000, 24'h4C0003};
	always #25 hclk = ~hclk;
	dfv_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .alt_ramp_sel(alt_sel),
		.speed_found(found), .drive(drive));
	dfv_motor u_motor (.hclk(hclk), .drive(drive), .spin_val(spin), .speed_found(found));
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// One single AHB transfer; address phase, then data phase, each held until hready.
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : 32'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask : rd
	// Compares each read data phase with the oldest noted expectation.
	always @(posedge hclk) begin
		if (rd_ph) begin
			cmp("hrdata", q.pop_front(), hrdata);
			cmp("hresp", 32'h0, {31'h0, hresp});
		end
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
	end
	function automatic logic [15:0] fld(input int s);
		case (s)
			0: return drive.freq;
			1: return drive.voltage;
			2: return {15'h0000, drive.running};
			3: return {15'h0000, drive.reverse};
			default: return {12'h000, drive.carrier};
		endcase
	endfunction : fld
	// Waits a bounded time for a drive field to reach a value, then compares it.
	task automatic wait_fld(input int s, input logic [15:0] v, input int lim);
		int n;
		n = 0;
		do begin @(negedge hclk); n++; end while (fld(s) !== v && n < lim);
		cmp($sformatf("drive field %0d", s), {16'h0000, v}, {16'h0000, fld(s)});
		@(posedge hclk);
	endtask : wait_fld
	// Measures the cycles between two consecutive frequency steps.
	task automatic gap(input int e);
		logic [15:0] f;
		int n;
		@(negedge hclk);
		for (int k = 0; k < 2; k++) begin
			f = drive.freq;
			n = 0;
			do begin @(negedge hclk); n++; end while (drive.freq === f && n < 400);
		end
		cmp("step spacing", e, n);
		@(posedge hclk);
	endtask : gap
	task automatic final_report();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	// Cuts a hang short.
	initial begin
		repeat (60000) @(posedge hclk);
		cmp("watchdog", 32'h0, 32'h1);
		final_report();
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (dfl[i]) rd(dfl[i][23:16], {16'h0000, dfl[i][15:0]});
		foreach (bad[i]) begin
			wr(bad[i][39:32], {16'h0000, bad[i][31:16]});
			rd(bad[i][39:32], {16'h0000, bad[i][15:0]});
		end
		rd(8'h50, 32'h00080000);
		wr(8'h08, 32'h9C40);
		rd(8'h08, 32'h9C40);
		rd(8'h50, 32'h00000000);
		car = 4'h1 + 4'($unsigned($random(seed)) % 15);
		wr(8'h38, {28'h0, car});
		rd(8'h38, {28'h0, car});
		wait_fld(4, {12'h000, car}, 20);
		wr(8'h40, 32'h1);
		wr(8'h3C, 32'h8);
		wr(8'h10, 32'h5);
		wr(8'h00, 32'h1234);
		rd(8'h38, {28'h0, car});
		rd(8'h10, 32'h46);
		rd(8'h00, 32'h1234);
		wr(8'h40, 32'h0);
		wr(8'h3C, 32'h8);
		rd(8'h38, 32'hA);
		rd(8'h08, 32'h1388);
		rd(8'h3C, 32'h0);
		foreach (cfg[i]) wr(cfg[i][23:16], {16'h0000, cfg[i][15:0]});
		wait_fld(0, 16'h0032, 10);
		wait_fld(2, 16'h0001, 2);
		wait_fld(3, 16'h0000, 1);
		gap(50);
		wait_fld(0, 16'h0064, 3000);
		wait_fld(1, 16'h03E8, 10);
		repeat (200) @(posedge hclk);
		wait_fld(0, 16'h0064, 1);
		alt_sel <= 1'b1;
		wr(8'h00, 32'hC8);
		gap(100);
		wait_fld(0, 16'h00C8, 12000);
		wait_fld(1, 16'h0514, 10);
		alt_sel <= 1'b0;
		wr(8'h4C, 32'h0);
		gap(50);
		wait_fld(2, 16'h0000, 12000);
		wr(8'h04, 32'h1);
		wr(8'h4C, 32'h3);
		wait_fld(3, 16'h0001, 100);
		wait_fld(2, 16'h0001, 100);
		wr(8'h4C, 32'h1);
		wait_fld(3, 16'h0000, 12000);
		wr(8'h4C, 32'h0);
		wait_fld(2, 16'h0000, 12000);
		spin <= 16'h9C3B;
		wr(8'h44, 32'h1);
		wr(8'h4C, 32'h1);
		wait_fld(0, 16'h9C40, 100);
		wait_fld(2, 16'h0001, 2);
		wait_fld(1, 16'h9470, 10);
		wait_fld(0, 16'h9C3A, 400);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		wait_fld(4, 16'h000A, 3);
		rd(8'h44, 32'h0);
		rd(8'h08, 32'h1388);
		repeat (2) @(posedge hclk);
		final_report();
	end
endmodule : dfv_core_tb
